// ### citarf_axil.sv
// AXI4-Lite slave front end for the register file
`timescale 1ns/1ps
module citarf_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  citarf_reg_if.slave bus
);
  import citarf_pkg::*;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} citarf_rd_e;
  citarf_rd_e rd_r;
  logic aw_have_r;
  logic w_have_r;
  logic [5:0] addr_r;
  logic [7:0] data_r;
  logic strb_r;
  logic wr_en_r;
  assign bus.wr_en = wr_en_r;
  assign bus.wr_addr = addr_r;
  assign bus.wr_data = data_r;
  assign bus.rd_addr = {araddr[5:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      addr_r <= 6'h00;
      data_r <= 8'h00;
      strb_r <= 1'b0;
      wr_en_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      wr_en_r <= 1'b0;
      if (awvalid && awready) begin
        addr_r <= {awaddr[5:2], 2'b00};
        aw_have_r <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        data_r <= wdata[7:0];
        strb_r <= wstrb[0];
        w_have_r <= 1'b1;
        wready <= 1'b0;
      end
      if (aw_have_r && w_have_r && !bvalid) begin
        // Only byte lane 0 carries register bits
        wr_en_r <= strb_r & citarf_mapped(addr_r);
        bresp <= citarf_mapped(addr_r) ? RESP_OKAY : RESP_SLVERR;
        bvalid <= 1'b1;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_r <= RD_IDLE;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      unique case (rd_r)
        RD_IDLE: if (arvalid) begin
          rdata <= {24'h000000, citarf_mapped(bus.rd_addr) ? bus.rd_data : 8'h00};
          rresp <= citarf_mapped(bus.rd_addr) ? RESP_OKAY : RESP_SLVERR;
          rvalid <= 1'b1;
          arready <= 1'b0;
          rd_r <= RD_DATA;
        end
        RD_DATA: if (rready) begin
          rvalid <= 1'b0;
          arready <= 1'b1;
          rd_r <= RD_IDLE;
        end
      endcase
    end
  end
endmodule : citarf_axil

// ### citarf_filter.sv
// Identifier acceptance filter, combinational
`timescale 1ns/1ps
module citarf_filter (
  input wire citarf_pkg::citarf_layout_e layout,
  input wire logic [3:0][7:0] code,
  input wire logic [3:0][7:0] ign,
  input wire logic [3:0][7:0] id,
  input wire logic ext,
  output logic accept,
  output logic [1:0] hit
);
  import citarf_pkg::*;
  logic [3:0] own;
  logic [3:0] first;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      own[k] = citarf_byte_hit(id[k], code[k], ign[k]);
      first[k] = citarf_byte_hit(id[0], code[k], ign[k]);
    end
  end
  // In the single 32-bit layout, standard frames use only the first two code/ignore pairs
  always_comb begin
    accept = 1'b0;
    hit = 2'h0;
    unique case (layout)
      LAY_ONE32: begin
        accept = own[0] & own[1] & (~ext | (own[2] & own[3]));
      end
      LAY_TWO16: begin
        if (own[0] & own[1]) begin
          accept = 1'b1;
        end else if (first[2] & citarf_byte_hit(id[1], code[3], ign[3])) begin
          accept = 1'b1;
          hit = 2'h1;
        end
      end
      LAY_FOUR8: begin
        accept = |first;
        hit = first[0] ? 2'h0 : first[1] ? 2'h1 : first[2] ? 2'h2 : 2'h3;
      end
      LAY_CLOSED: begin
        accept = 1'b0;
      end
    endcase
  end
endmodule : citarf_filter

// ### citarf_node_model.sv
// Bus-side transmit engine model: sends, stalls or fails scheduled buffers
`timescale 1ns/1ps
module citarf_node_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hold,
  input wire logic fail,
  input wire logic [2:0] tx_pending,
  output logic [2:0] tx_sent,
  output logic [2:0] tx_active,
  output logic [2:0] tx_failed
);
  logic [3:0] cnt_r;
  // Idle gap after each frame so a stale pending bit is never restarted
  always_ff @(posedge aclk) begin
    tx_sent <= 3'h0;
    tx_failed <= 3'h0;
    if (!aresetn) begin
      tx_active <= 3'h0;
      cnt_r <= 4'h0;
    end else if (tx_active == 3'h0) begin
      if (cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
      else if (!hold && tx_pending != 3'h0) begin
        tx_active <= tx_pending & (~tx_pending + 3'h1);
        cnt_r <= 4'h0;
      end
    end else if (!hold) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == 4'h7) begin
        if (fail) tx_failed <= tx_active;
        else tx_sent <= tx_active;
        tx_active <= 3'h0;
      end
    end
  end
endmodule : citarf_node_model

// ### citarf_pkg.sv
// Shared constants, types and helpers for the CAN control register block
package citarf_pkg;
  localparam int unsigned AW = 6;
  localparam int unsigned NBUF = 3;
  // Register byte offsets
  localparam logic [5:0] ADDR_MCTL = 6'h00;
  localparam logic [5:0] ADDR_RIER = 6'h04;
  localparam logic [5:0] ADDR_TFLG = 6'h08;
  localparam logic [5:0] ADDR_TCR = 6'h0c;
  localparam logic [5:0] ADDR_FCTL = 6'h10;
  localparam logic [5:0] ADDR_RXERR = 6'h14;
  localparam logic [5:0] ADDR_TXERR = 6'h18;
  localparam logic [5:0] ADDR_CODE0 = 6'h20;
  localparam logic [5:0] ADDR_IGN0 = 6'h30;
  // Field positions
  localparam int unsigned MCTL_SRST_BIT = 0;
  localparam int unsigned RIER_WAKE_BIT = 7;
  localparam int unsigned RIER_ERR_LSB = 1;
  localparam int unsigned RIER_RXF_BIT = 0;
  localparam int unsigned TFLG_ABT_LSB = 4;
  localparam int unsigned TFLG_TXE_LSB = 0;
  localparam int unsigned TCR_AR_LSB = 4;
  localparam int unsigned TCR_IE_LSB = 0;
  localparam int unsigned FCTL_LAYOUT_LSB = 4;
  localparam int unsigned FCTL_HIT_LSB = 0;
  // Reset values
  localparam logic SRST_RST = 1'b1;
  localparam logic [7:0] RIER_RST = 8'h00;
  localparam logic [2:0] TXE_RST = 3'h7;
  localparam logic [2:0] ABT_RST = 3'h0;
  localparam logic [2:0] AR_RST = 3'h0;
  localparam logic [2:0] TX_EMPTY_IRQ_EN_RST = 3'h0;
  localparam logic [1:0] HIT_RST = 2'h0;
  localparam logic [7:0] FILT_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LAY_ONE32 = 2'h0,
    LAY_TWO16 = 2'h1,
    LAY_FOUR8 = 2'h2,
    LAY_CLOSED = 2'h3
  } citarf_layout_e;

  function automatic logic citarf_byte_hit(input logic [7:0] id, input logic [7:0] code, input logic [7:0] ign);
    citarf_byte_hit = &(~(id ^ code) | ign);
  endfunction : citarf_byte_hit

  function automatic logic citarf_mapped(input logic [5:0] a);
    citarf_mapped = (a <= ADDR_TXERR) || (a >= ADDR_CODE0);
  endfunction : citarf_mapped
endpackage : citarf_pkg

// ### citarf_reg_if.sv
// Register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface citarf_reg_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  modport slave (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport regs (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : citarf_reg_if

// ### citarf_top.sv
// CAN interrupt enables, transmit flags, abort control and acceptance filter registers
// Functional notes
// - Wake-up event raises wake interrupt only while its enable bit is one.
// - Six error enables route warning, passive, bus-off, overrun onto error interrupt.
// - Receive-full event raises receive interrupt only while its enable is set.
// - Soft reset holds the receive interrupt enable register at reset value.
// - Writing one clears a transmit-empty flag; zero no effect; acknowledges ignore writes.
// - Clearing transmit-empty also clears that buffer's abort acknowledge flag.
// - Transmit-empty sets after successful send or after a granted abort.
// - Abort request clears automatically whenever that buffer's empty flag is set.
// - Abort granted if not started or after failure; sets empty and acknowledge.
// - Software can only set abort requests; writing zero leaves them alone.
// - Each of three buffers has an empty interrupt enable bit.
// - Transmit flags reset by hard and soft reset, held during soft reset.
// - Soft reset holds the transmit control register at reset value.
// - Layout selects one 32, two 16, four 8-bit filters, or closed.
// - Match index reports hit filter, updated on each foreground load.
// - Filter control, code and ignore registers writable only during soft reset.
// - Only accepted frames are passed on; rejected ones are simply overwritten.
// - In the 32-bit layout extended frames use all four pairs; standard frames only the first two.
// - Ignore bit zero demands equality, one makes bit irrelevant; all must match.
// - No foreground load while receive-full is set; match index holds.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module citarf_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wake_flag,
  input wire logic [5:0] err_flags,
  input wire logic rx_full_flag,
  input wire logic rx_frame_valid,
  input wire logic [31:0] rx_frame_id,
  input wire logic rx_frame_ext,
  input wire logic [7:0] rx_err_count,
  input wire logic [7:0] tx_err_count,
  input wire logic [2:0] tx_sent,
  input wire logic [2:0] tx_active,
  input wire logic [2:0] tx_failed,
  output logic soft_reset,
  output logic rx_load,
  output logic [1:0] rx_load_index,
  output logic [2:0] tx_pending,
  output logic [2:0] tx_abort,
  output logic irq_wake,
  output logic irq_err,
  output logic irq_rx,
  output logic irq_txe
);
  import citarf_pkg::*;

  citarf_reg_if rif ();

  logic soft_reset_bit_r;
  logic [7:0] receive_irq_enable_r;
  logic [2:0] tx_buffer_empty_r;
  logic [2:0] tx_buffer_empty_nxt;
  logic [2:0] abort_done_flag_r;
  logic [2:0] abort_done_flag_nxt;
  logic [2:0] abort_request_r;
  logic [2:0] abort_request_nxt;
  logic [2:0] tx_empty_irq_en_r;
  citarf_layout_e filter_layout_r;
  logic [1:0] filter_match_index_r;
  logic [3:0][7:0] filter_code_r;
  logic [3:0][7:0] filter_ignore_r;
  logic wr_mctl;
  logic wr_rier;
  logic wr_tflg;
  logic wr_tcr;
  logic wr_fctl;
  logic [2:0] txe_clr;
  logic [2:0] txe_set;
  logic [2:0] abort_grant;
  logic [2:0] ar_set;
  logic flt_accept;
  logic [1:0] flt_hit;
  logic [7:0] rd_mux;

  citarf_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .bus(rif.slave)
  );

  citarf_filter u_filter (
    .layout(filter_layout_r),
    .code(filter_code_r),
    .ign(filter_ignore_r),
    .id({rx_frame_id[7:0], rx_frame_id[15:8], rx_frame_id[23:16], rx_frame_id[31:24]}),
    .ext(rx_frame_ext),
    .accept(flt_accept),
    .hit(flt_hit)
  );

  // Write decode
  always_comb begin
    wr_mctl = rif.wr_en && (rif.wr_addr == ADDR_MCTL);
    wr_rier = rif.wr_en && (rif.wr_addr == ADDR_RIER);
    wr_tflg = rif.wr_en && (rif.wr_addr == ADDR_TFLG);
    wr_tcr = rif.wr_en && (rif.wr_addr == ADDR_TCR);
    wr_fctl = rif.wr_en && (rif.wr_addr == ADDR_FCTL) && soft_reset_bit_r;
  end

  // Transmit flag and abort bookkeeping
  always_comb begin
    txe_clr = wr_tflg ? rif.wr_data[TFLG_TXE_LSB +: NBUF] : 3'h0;
    ar_set = wr_tcr ? rif.wr_data[TCR_AR_LSB +: NBUF] : 3'h0;
    // A running frame may only be dropped once it has failed
    // A frame reported sent in this cycle went out; it must not read as aborted
    abort_grant = abort_request_r & ~tx_buffer_empty_r & ~tx_sent & (~tx_active | tx_failed);
    txe_set = (tx_sent & ~tx_buffer_empty_r) | abort_grant;
    // Set wins over a clear in the same cycle
    tx_buffer_empty_nxt = txe_set | (tx_buffer_empty_r & ~txe_clr);
    abort_done_flag_nxt = abort_grant | (abort_done_flag_r & ~txe_clr & ~txe_set);
    abort_request_nxt = (abort_request_r | ar_set) & ~tx_buffer_empty_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_reset_bit_r <= SRST_RST;
    end else if (ce && wr_mctl) begin
      soft_reset_bit_r <= rif.wr_data[MCTL_SRST_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_irq_enable_r <= RIER_RST;
    end else if (ce) begin
      if (soft_reset_bit_r) begin
        receive_irq_enable_r <= RIER_RST;
      end else if (wr_rier) begin
        receive_irq_enable_r <= rif.wr_data;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buffer_empty_r <= TXE_RST;
      abort_done_flag_r <= ABT_RST;
    end else if (ce) begin
      if (soft_reset_bit_r) begin
        tx_buffer_empty_r <= TXE_RST;
        abort_done_flag_r <= ABT_RST;
      end else begin
        tx_buffer_empty_r <= tx_buffer_empty_nxt;
        abort_done_flag_r <= abort_done_flag_nxt;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_request_r <= AR_RST;
      tx_empty_irq_en_r <= TX_EMPTY_IRQ_EN_RST;
    end else if (ce) begin
      if (soft_reset_bit_r) begin
        abort_request_r <= AR_RST;
        tx_empty_irq_en_r <= TX_EMPTY_IRQ_EN_RST;
      end else begin
        abort_request_r <= abort_request_nxt;
        if (wr_tcr) begin
          tx_empty_irq_en_r <= rif.wr_data[TCR_IE_LSB +: NBUF];
        end
      end
    end
  end

  // Filter setup is frozen outside soft reset so a live filter never changes mid-frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_layout_r <= LAY_ONE32;
      filter_code_r <= {4{FILT_RST}};
      filter_ignore_r <= {4{FILT_RST}};
    end else if (ce && rif.wr_en && soft_reset_bit_r) begin
      if (wr_fctl) begin
        filter_layout_r <= citarf_layout_e'(rif.wr_data[FCTL_LAYOUT_LSB +: 2]);
      end
      for (int k = 0; k < 4; k++) begin
        if (rif.wr_addr == ADDR_CODE0 + 6'(4 * k)) begin
          filter_code_r[k] <= rif.wr_data;
        end
        if (rif.wr_addr == ADDR_IGN0 + 6'(4 * k)) begin
          filter_ignore_r[k] <= rif.wr_data;
        end
      end
    end
  end

  // Foreground load and match index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_load <= 1'b0;
      filter_match_index_r <= HIT_RST;
    end else if (ce) begin
      rx_load <= 1'b0;
      // Held frame blocks the swap; rejected frames are left for overwrite
      if (rx_frame_valid && flt_accept && !rx_full_flag && !soft_reset_bit_r) begin
        rx_load <= 1'b1;
        filter_match_index_r <= flt_hit;
      end
    end
  end

  // Interrupt outputs follow flag AND enable, one cycle behind
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_wake <= 1'b0;
      irq_err <= 1'b0;
      irq_rx <= 1'b0;
      irq_txe <= 1'b0;
    end else if (ce) begin
      irq_wake <= wake_flag & receive_irq_enable_r[RIER_WAKE_BIT];
      irq_err <= |(err_flags & receive_irq_enable_r[RIER_ERR_LSB +: 6]);
      irq_rx <= rx_full_flag & receive_irq_enable_r[RIER_RXF_BIT];
      irq_txe <= |(tx_buffer_empty_r & tx_empty_irq_en_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_reset <= SRST_RST;
      tx_pending <= 3'h0;
      tx_abort <= AR_RST;
      rx_load_index <= HIT_RST;
    end else if (ce) begin
      soft_reset <= soft_reset_bit_r;
      tx_pending <= ~tx_buffer_empty_r;
      tx_abort <= abort_request_r;
      rx_load_index <= filter_match_index_r;
    end
  end

  // Read mux
  always_comb begin
    rd_mux = 8'h00;
    unique case (rif.rd_addr)
      ADDR_MCTL: rd_mux[MCTL_SRST_BIT] = soft_reset_bit_r;
      ADDR_RIER: rd_mux = receive_irq_enable_r;
      ADDR_TFLG: rd_mux = {1'b0, abort_done_flag_r, 1'b0, tx_buffer_empty_r};
      ADDR_TCR: rd_mux = {1'b0, abort_request_r, 1'b0, tx_empty_irq_en_r};
      ADDR_FCTL: rd_mux = {2'b00, filter_layout_r, 2'b00, filter_match_index_r};
      ADDR_RXERR: rd_mux = rx_err_count;
      ADDR_TXERR: rd_mux = tx_err_count;
      default: begin
        for (int k = 0; k < 4; k++) begin
          if (rif.rd_addr == ADDR_CODE0 + 6'(4 * k)) begin
            rd_mux = filter_code_r[k];
          end
          if (rif.rd_addr == ADDR_IGN0 + 6'(4 * k)) begin
            rd_mux = filter_ignore_r[k];
          end
        end
      end
    endcase
  end
  assign rif.rd_data = rd_mux;
endmodule : citarf_top

// ### citarf_top_asserts.sv
// Port-level timing checks for the CAN control register block
`timescale 1ns/1ps
module citarf_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic wake_flag,
  input wire logic [5:0] err_flags,
  input wire logic rx_full_flag,
  input wire logic rx_frame_valid,
  input wire logic soft_reset,
  input wire logic rx_load,
  input wire logic [2:0] tx_pending,
  input wire logic [2:0] tx_abort,
  input wire logic irq_wake,
  input wire logic irq_err,
  input wire logic irq_rx,
  input wire logic irq_txe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_resp_held;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  // Second cycle lets the registered outputs catch up with the held state
  sequence s_srst_settled;
    soft_reset ##1 soft_reset;
  endsequence
  a_wake_cause: assert property (irq_wake |-> $past(wake_flag)) else $error("wake irq without flag");
  a_err_cause: assert property (irq_err |-> $past(err_flags) != 6'h0) else $error("err irq without flag");
  a_rx_cause: assert property (irq_rx |-> $past(rx_full_flag)) else $error("rx irq without flag");
  a_srst_quiet: assert property (s_srst_settled |-> !irq_wake && !irq_err && !irq_rx && !irq_txe
    && tx_pending == 3'h0 && tx_abort == 3'h0) else $error("state not held in soft reset");
  a_abort_empty: assert property ((~tx_pending & ~$past(tx_pending) & tx_abort) == 3'h0)
    else $error("abort stays on empty buffer");
  a_abort_rise: assert property ((tx_abort & ~$past(tx_abort) & ~tx_pending) == 3'h0)
    else $error("abort raised on empty buffer");
  a_txe_source: assert property (irq_txe |-> tx_pending != 3'h7) else $error("txe irq with no empty");
  a_load_cause: assert property (rx_load |-> $past(rx_frame_valid) && !$past(rx_full_flag))
    else $error("load without frame or while full");
  a_resp_hold: assert property (s_resp_held |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
endmodule : citarf_top_asserts
bind citarf_top citarf_top_asserts u_chk (.*);

// ### citarf_top_test.sv
// Random and directed bench for the CAN control register block
`timescale 1ns/1ps
module citarf_top_test;
  import citarf_pkg::*;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, hold, fail;
  logic wake_flag, rx_full_flag, rx_frame_valid, rx_frame_ext, soft_reset, rx_load, irq_wake, irq_err, irq_rx, irq_txe;
  logic [5:0] s_axi_awaddr, s_axi_araddr, err_flags;
  logic [31:0] s_axi_wdata, s_axi_rdata, rx_frame_id, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_load_index, exp_idx;
  logic [7:0] rx_err_count, tx_err_count, en;
  logic [2:0] tx_sent, tx_active, tx_failed, tx_pending, tx_abort;
  logic [3:0][7:0] code, ign;
  int n_errors, samples_checked, k, i, j;
  citarf_top dut (.*);
  citarf_node_model node (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bound;
    if (k >= 99) begin
      n_errors++;
      summarize();
    end
  endtask : bound
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Late bready lets the response wait with bvalid high
    for (k = 0; k < 99 && !done; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (k == 2) s_axi_bready <= 1'b1;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        done = 1'b1;
      end
    end
    bound();
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    bound();
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, e});
    chk(s_axi_rresp, er);
  endtask : rd
  function automatic logic bm(input logic [7:0] a, input int n);
    return &(~(a ^ code[n]) | ign[n]);
  endfunction : bm
  // Returns accept in bit 2 and the lowest matching filter below it
  function automatic logic [2:0] fexp(input logic [1:0] lay, input logic [31:0] id, input logic ext);
    logic [3:0] g;
    g = 4'h0;
    if (lay == 2'h0) g[0] = bm(id[31:24], 0) & bm(id[23:16], 1) & (!ext | (bm(id[15:8], 2) & bm(id[7:0], 3)));
    if (lay == 2'h1) g[1:0] = {bm(id[31:24], 2) & bm(id[23:16], 3), bm(id[31:24], 0) & bm(id[23:16], 1)};
    if (lay == 2'h2) g = {bm(id[31:24], 3), bm(id[31:24], 2), bm(id[31:24], 1), bm(id[31:24], 0)};
    fexp = 3'h0;
    for (int n = 3; n >= 0; n--) if (g[n]) fexp = {1'b1, 2'(n)};
  endfunction : fexp
  task automatic frame(input logic [1:0] lay);
    logic [31:0] r, id;
    logic [2:0] e;
    logic ok;
    r = rnd();
    id = {code[0], code[1], code[2], code[3]};
    if (lay == 2'h1) id = {code[{r[0], 1'b0}], code[{r[0], 1'b1}], r[15:0]};
    if (lay == 2'h2) id = {code[r[1:0]], r[23:0]};
    if (r[3:2] == 2'h0) id = id ^ (32'h1 << r[8:4]);
    e = fexp(lay, id, r[9]);
    ok = e[2] && r[11:10] != 2'h0;
    @(posedge aclk);
    rx_frame_id <= id;
    rx_frame_ext <= r[9];
    rx_full_flag <= r[11:10] == 2'h0;
    rx_frame_valid <= 1'b1;
    @(posedge aclk);
    rx_frame_valid <= 1'b0;
    #1;
    chk(rx_load, ok);
    if (ok) exp_idx = e[1:0];
    @(posedge aclk);
    #1;
    chk(rx_load_index, exp_idx);
  endtask : frame
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fail, aresetn} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_frame_id, err_flags} = 82'h0;
    {wake_flag, rx_full_flag, rx_frame_valid, rx_frame_ext, exp_idx} = 6'h0;
    s_axi_wstrb = 4'h1;
    {hold, ce} = 2'h3;
    seed = 32'ha1df;
    {tx_err_count, rx_err_count} = 16'(rnd());
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_MCTL, 8'h01);
    rd(ADDR_RIER, RIER_RST);
    rd(ADDR_TFLG, {5'h0, TXE_RST});
    rd(ADDR_TCR, 8'h00);
    rd(ADDR_RXERR, rx_err_count);
    rd(ADDR_TXERR, tx_err_count);
    rd(6'h1c, 8'h00, RESP_SLVERR);
    wr(6'h1c, 8'hff, RESP_SLVERR);
    s_axi_wstrb <= 4'he;
    wr(ADDR_MCTL, 8'h00);
    s_axi_wstrb <= 4'h1;
    rd(ADDR_MCTL, 8'h01);
    $display("register map test done");
    for (i = 0; i < 4; i++) begin
      wr(ADDR_MCTL, 8'h01);
      for (j = 0; j < 4; j++) {code[j], ign[j]} = {8'(rnd()), 8'(rnd() & rnd())};
      ign[1] = ign[1] | 8'h07;
      for (j = 0; j < 4; j++) wr(ADDR_CODE0 + 6'(4 * j), code[j]);
      for (j = 0; j < 4; j++) wr(ADDR_IGN0 + 6'(4 * j), ign[j]);
      wr(ADDR_FCTL, {2'h0, 2'(i), 4'h0});
      wr(ADDR_MCTL, 8'h00);
      wr(ADDR_CODE0, ~code[0]);
      rd(ADDR_CODE0, code[0]);
      repeat (16) frame(2'(i));
      rd(ADDR_FCTL, {2'h0, 2'(i), 2'h0, exp_idx});
    end
    $display("filter test done");
    for (i = 0; i < 24; i++) begin
      en = 8'h1 << (i % 8);
      wr(ADDR_RIER, en);
      {wake_flag, rx_full_flag, err_flags} <= 8'(rnd());
      repeat (2) @(posedge aclk);
      #1;
      chk(irq_wake, en[7] & wake_flag);
      chk(irq_err, |(en[6:1] & err_flags));
      chk(irq_rx, en[0] & rx_full_flag);
    end
    wr(ADDR_MCTL, 8'h01);
    wr(ADDR_RIER, 8'hff);
    rd(ADDR_RIER, 8'h00);
    wr(ADDR_MCTL, 8'h00);
    $display("interrupt test done");
    wr(ADDR_TCR, 8'h07);
    repeat (2) @(posedge aclk);
    #1;
    chk(irq_txe, 1'b1);
    wr(ADDR_TFLG, 8'h70);
    rd(ADDR_TFLG, 8'h07);
    wr(ADDR_TFLG, 8'h02);
    rd(ADDR_TFLG, 8'h05);
    wr(ADDR_TCR, 8'h27);
    rd(ADDR_TFLG, 8'h27);
    rd(ADDR_TCR, 8'h07);
    wr(ADDR_TFLG, 8'h02);
    rd(ADDR_TFLG, 8'h05);
    hold <= 1'b0;
    for (k = 0; k < 99 && tx_pending != 3'h0; k++) @(posedge aclk);
    bound();
    rd(ADDR_TFLG, 8'h07);
    wr(ADDR_TFLG, 8'h01);
    for (k = 0; k < 99 && tx_active == 3'h0; k++) @(posedge aclk);
    bound();
    hold <= 1'b1;
    wr(ADDR_TCR, 8'h17);
    wr(ADDR_TCR, 8'h07);
    rd(ADDR_TCR, 8'h17);
    chk({soft_reset, tx_abort, tx_pending}, 7'h09);
    {fail, hold} <= 2'h2;
    for (k = 0; k < 99 && tx_pending != 3'h0; k++) @(posedge aclk);
    bound();
    rd(ADDR_TFLG, 8'h17);
    {fail, hold} <= 2'h1;
    wr(ADDR_TCR, 8'h00);
    repeat (2) @(posedge aclk);
    #1;
    chk(irq_txe, 1'b0);
    $display("transmit test done");
    wr(ADDR_TFLG, 8'h04);
    wr(ADDR_TCR, 8'h47);
    wr(ADDR_MCTL, 8'h01);
    rd(ADDR_TFLG, 8'h07);
    rd(ADDR_TCR, 8'h00);
    chk({soft_reset, tx_abort, tx_pending}, 7'h40);
    $display("soft reset test done");
    summarize();
  end
endmodule : citarf_top_test
